// ### rx_par_out.sv
// The implementer's own choices: register access over Wishbone and the register offsets.
module rx_par_out
(
    input  wire logic        clk_i,                    // 25 MHz bit clock
    input  wire logic        rst_i,                    // synchronous reset, high
    input  wire logic        rx_serial_i,              // serial receive stream
    input  wire logic        optical_signal_detect_i,  // signal detect from module
    input  wire logic        sd_polarity_i,            // high: detect active high
    input  wire logic        mute_on_los_i,            // mute pin, hardware mode
    input  wire logic        host_mode_i,              // high: host mode
    input  wire logic        cdr_lock_i,               // lock state of recovery
    input  wire logic        fec_rate_i,               // high: fec rate selected
    input  wire logic        rx_data_disable_i,        // asynchronous lane disable
    output logic [3:0]       rx_par_data_o,            // parallel receive data
    output logic             rx_par_clk_out_o,         // forwarded parallel clock
    output logic             rx_aux_div16_clk_o,       // divide-by-16 clock
    output logic             recovery_lock_ind_o,      // lock indicator
    output logic             los_flag_out_o,           // loss of signal flag
    output logic             irq_o,                    // level interrupt
    input  wire logic        wb_cyc_i,                 // wishbone cycle
    input  wire logic        wb_stb_i,                 // wishbone strobe
    input  wire logic        wb_we_i,                  // wishbone write
    input  wire logic [3:0]  wb_adr_i,                 // wishbone byte address
    input  wire logic [3:0]  wb_sel_i,                 // wishbone byte lanes
    input  wire logic [31:0] wb_dat_i,                 // wishbone write data
    output logic [31:0]      wb_dat_o,                 // wishbone read data
    output logic             wb_ack_o                  // wishbone acknowledge
);

    // ****************************************
    // pin synchronisers
    // ****************************************
    logic [rx_out_pkg::PIN_W-1:0] pin_raw;
    logic [rx_out_pkg::PIN_W-1:0] sync1;
    logic [rx_out_pkg::PIN_W-1:0] sync2;
    logic [rx_out_pkg::PIN_W-1:0] sync3;
    logic [rx_out_pkg::PIN_W-1:0] pin;
    logic [rx_out_pkg::PIN_W-1:0] next_pin;

    // gather the pins in slot order
    assign pin_raw = {cdr_lock_i, host_mode_i, mute_on_los_i,
                      sd_polarity_i, optical_signal_detect_i, rx_serial_i};

    // a slot changes once stages two and three agree; the serial slot runs on
    // the recovery clock and changes every cycle, so it passes unfiltered
    always_comb
    begin
        for (int i = 0; i < rx_out_pkg::PIN_W; i++)
        begin
            next_pin[i] = (i == rx_out_pkg::PIN_SERIAL || sync2[i] == sync3[i]) ? sync3[i] : pin[i];
        end
    end

    // register the three stages and the accepted value
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync1 <= rx_out_pkg::PIN_RESET;
            sync2 <= rx_out_pkg::PIN_RESET;
            sync3 <= rx_out_pkg::PIN_RESET;
            pin   <= rx_out_pkg::PIN_RESET;
        end
        else
        begin
            sync1 <= pin_raw;
            sync2 <= sync1;
            sync3 <= sync2;
            pin   <= next_pin;
        end
    end

    // ****************************************
    // deserialiser
    // ****************************************
    deser_if lane ();

    assign lane.serial_bit = pin[rx_out_pkg::PIN_SERIAL];

    rx_deser4 deser
    (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .lane  (lane.deser)
    );

    // ****************************************
    // loss of signal and mute decision
    // ****************************************
    logic        sd_active;
    logic        los_now;
    logic        mute_src;
    logic        muted;
    logic [31:0] ctrl;

    // polarity low means detect is active low
    assign sd_active = pin[rx_out_pkg::PIN_SDET] ~^ pin[rx_out_pkg::PIN_POL];
    assign los_now   = ~sd_active;
    // mute source depends on mode
    assign mute_src  = pin[rx_out_pkg::PIN_HOST] ? ctrl[rx_out_pkg::CTRL_MUTE_BIT]
                                                 : pin[rx_out_pkg::PIN_MUTE];
    assign muted     = los_now & mute_src;

    // ****************************************
    // output stage
    // ****************************************
    logic [3:0] data_q;
    logic       pclk_q;
    logic       aux_q;
    logic       lock_q;
    logic       los_q;
    logic [3:0] next_data_q;

    // muted lanes go to zero; a new group loads only as the parallel clock rises
    always_comb
    begin
        next_data_q = data_q;
        if (muted)
        begin
            next_data_q = 4'h0;
        end
        else if (lane.par_clk && !pclk_q)
        begin
            next_data_q = lane.word;
        end
    end

    // data and its clock pass one flop together
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            data_q <= 4'h0;
            pclk_q <= 1'b0;
            aux_q  <= 1'b0;
            lock_q <= 1'b0;
            los_q  <= 1'b0;
        end
        else
        begin
            data_q <= next_data_q;
            pclk_q <= lane.par_clk;
            aux_q  <= lane.aux_clk;
            lock_q <= pin[rx_out_pkg::PIN_LOCK];
            los_q  <= los_now;
        end
    end

    // disable gates the lanes with no clock involved
    assign rx_par_data_o      = rx_data_disable_i ? 4'h0 : data_q;
    assign rx_par_clk_out_o   = pclk_q;
    assign rx_aux_div16_clk_o = aux_q;
    assign recovery_lock_ind_o = lock_q;
    assign los_flag_out_o     = los_q;

    // ****************************************
    // events and interrupt
    // ****************************************
    logic [1:0] int_stat;
    logic [1:0] int_mask;
    logic [1:0] event_set;
    logic [1:0] next_int_stat;
    logic [1:0] next_int_mask;
    logic       irq_q;
    logic       los_prev;
    logic       lock_prev;
    logic [31:0] next_ctrl;
    logic       wr_stb;
    logic       rd_stb;

    // loss recorded only in host mode; lock loss always
    always_comb
    begin
        event_set = 2'h0;
        event_set[rx_out_pkg::EV_LOS_BIT]    = los_q & ~los_prev & pin[rx_out_pkg::PIN_HOST];
        event_set[rx_out_pkg::EV_UNLOCK_BIT] = lock_prev & ~lock_q;
    end

    // write one clears, a new event wins over the clear
    always_comb
    begin
        next_int_stat = int_stat;
        next_int_mask = int_mask;
        next_ctrl     = ctrl;
        if (wr_stb && wb_sel_i[0])
        begin
            unique case (wb_adr_i)
                rx_out_pkg::CTRL_ADDR:     next_ctrl = {ctrl[31:8], wb_dat_i[7:0]} & 32'h00000001;
                rx_out_pkg::INT_STAT_ADDR: next_int_stat = int_stat & ~wb_dat_i[1:0];
                rx_out_pkg::INT_MASK_ADDR: next_int_mask = wb_dat_i[1:0];
                default:                   next_ctrl = ctrl;
            endcase
        end
        next_int_stat = next_int_stat | event_set;
    end

    // register control, status and interrupt
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl      <= rx_out_pkg::CTRL_RESET;
            int_stat  <= rx_out_pkg::EV_RESET;
            int_mask  <= rx_out_pkg::EV_RESET;
            irq_q     <= 1'b0;
            los_prev  <= 1'b0;
            lock_prev <= 1'b0;
        end
        else
        begin
            ctrl      <= next_ctrl;
            int_stat  <= next_int_stat;
            int_mask  <= next_int_mask;
            irq_q     <= |(next_int_stat & next_int_mask);
            los_prev  <= los_q;
            lock_prev <= lock_q;
        end
    end

    assign irq_o = irq_q;

    // ****************************************
    // wishbone slave
    // ****************************************
    logic        ack_q;
    logic [31:0] rdata_q;
    logic [31:0] next_rdata;
    logic [31:0] status_word;

    // a write lands on the edge at which the master samples ack
    assign wr_stb = wb_cyc_i & wb_stb_i & ack_q & wb_we_i;
    assign rd_stb = wb_cyc_i & wb_stb_i & ~ack_q & ~wb_we_i;

    // live status word
    always_comb
    begin
        status_word = 32'h00000000;
        status_word[rx_out_pkg::ST_LOS_BIT]   = los_q;
        status_word[rx_out_pkg::ST_LOCK_BIT]  = lock_q;
        status_word[rx_out_pkg::ST_HOST_BIT]  = pin[rx_out_pkg::PIN_HOST];
        status_word[rx_out_pkg::ST_FEC_BIT]   = fec_rate_i;
        status_word[rx_out_pkg::ST_MUTED_BIT] = muted;
    end

    // read mux, unmapped reads zero
    always_comb
    begin
        next_rdata = rdata_q;
        if (rd_stb)
        begin
            unique case (wb_adr_i)
                rx_out_pkg::CTRL_ADDR:     next_rdata = ctrl;
                rx_out_pkg::STATUS_ADDR:   next_rdata = status_word;
                rx_out_pkg::INT_STAT_ADDR: next_rdata = {30'h00000000, int_stat};
                rx_out_pkg::INT_MASK_ADDR: next_rdata = {30'h00000000, int_mask};
                default:                   next_rdata = 32'h00000000;
            endcase
        end
    end

    // one-cycle acknowledge, dropped the cycle after
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q   <= 1'b0;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            ack_q   <= wb_cyc_i & wb_stb_i & ~ack_q;
            rdata_q <= next_rdata;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = rdata_q;

endmodule : rx_par_out

// ### rx_out_pkg.sv
package rx_out_pkg;

    // ****************************************
    // lane and clock structure
    // ****************************************
    localparam int unsigned LANES          = 4;
    localparam int unsigned AUX_DIVIDE     = 16;
    localparam int unsigned AUX_CNT_W      = 4;
    localparam int unsigned LANE_CNT_W     = 2;
    localparam logic [1:0]  LANE_LAST      = 2'h3;
    localparam logic [1:0]  PCLK_FALL      = 2'h1;

    // ****************************************
    // nominal rates, informational (kbit/s and kHz)
    // ****************************************
    localparam int unsigned SERIAL_NORMAL_KBPS = 2488000;
    localparam int unsigned SERIAL_FEC_KBPS    = 2666000;
    localparam int unsigned LANE_NORMAL_KBPS   = 622000;
    localparam int unsigned LANE_FEC_KBPS      = 666510;
    localparam int unsigned PCLK_NORMAL_KHZ    = 622080;
    localparam int unsigned PCLK_FEC_KHZ       = 666510;
    localparam int unsigned AUX_NORMAL_KHZ     = 155520;
    localparam int unsigned AUX_FEC_KHZ        = 166630;

    // ****************************************
    // register map, byte addresses
    // ****************************************
    localparam int unsigned ADDR_W         = 4;
    localparam logic [3:0]  CTRL_ADDR      = 4'h0;
    localparam logic [3:0]  STATUS_ADDR    = 4'h4;
    localparam logic [3:0]  INT_STAT_ADDR  = 4'h8;
    localparam logic [3:0]  INT_MASK_ADDR  = 4'hC;

    // ctrl fields
    localparam int unsigned CTRL_MUTE_BIT  = 0;
    localparam logic [31:0] CTRL_RESET     = 32'h00000000;

    // status fields (live)
    localparam int unsigned ST_LOS_BIT     = 0;
    localparam int unsigned ST_LOCK_BIT    = 1;
    localparam int unsigned ST_HOST_BIT    = 2;
    localparam int unsigned ST_FEC_BIT     = 3;
    localparam int unsigned ST_MUTED_BIT   = 4;

    // interrupt fields
    localparam int unsigned EV_W           = 2;
    localparam int unsigned EV_LOS_BIT     = 0;
    localparam int unsigned EV_UNLOCK_BIT  = 1;
    localparam logic [1:0]  EV_RESET       = 2'h0;

    // ****************************************
    // pin synchroniser slots
    // ****************************************
    localparam int unsigned PIN_W          = 6;
    localparam int unsigned PIN_SERIAL     = 0;
    localparam int unsigned PIN_SDET       = 1;
    localparam int unsigned PIN_POL        = 2;
    localparam int unsigned PIN_MUTE       = 3;
    localparam int unsigned PIN_HOST       = 4;
    localparam int unsigned PIN_LOCK       = 5;
    localparam logic [5:0]  PIN_RESET      = 6'h00;

endpackage : rx_out_pkg

// ### deser_if.sv
interface deser_if;

    logic                               serial_bit;  // synchronised serial bit, unfiltered, one per clk
    logic [rx_out_pkg::LANES-1:0]       word;        // last complete 4-bit group
    logic                               par_clk;     // parallel clock, rises with word
    logic                               aux_clk;     // divide-by-16 clock

    modport deser
    (
        input  serial_bit,
        output word,
        output par_clk,
        output aux_clk
    );

    modport ctrl
    (
        output serial_bit,
        input  word,
        input  par_clk,
        input  aux_clk
    );

endinterface : deser_if

// ### rx_deser4.sv
module rx_deser4
(
    input  wire logic   clk_i,    // bit clock
    input  wire logic   rst_i,    // synchronous reset, high
    deser_if.deser      lane      // stream and derived clocks
);

    // ****************************************
    // state
    // ****************************************
    logic [rx_out_pkg::LANES-1:0]      shift;
    logic [rx_out_pkg::LANE_CNT_W-1:0] bit_cnt;
    logic [rx_out_pkg::AUX_CNT_W-1:0]  aux_cnt;
    logic [rx_out_pkg::LANES-1:0]      word;
    logic                              par_clk;
    logic [rx_out_pkg::LANES-1:0]      next_shift;
    logic [rx_out_pkg::LANE_CNT_W-1:0] next_bit_cnt;
    logic [rx_out_pkg::AUX_CNT_W-1:0]  next_aux_cnt;
    logic [rx_out_pkg::LANES-1:0]      next_word;
    logic                              next_par_clk;

    // shift msb first, load a group every fourth bit
    always_comb
    begin
        next_shift   = {shift[rx_out_pkg::LANES-2:0], lane.serial_bit};
        next_bit_cnt = bit_cnt + 2'h1;
        next_aux_cnt = aux_cnt + 4'h1;
        next_word    = word;
        next_par_clk = par_clk;
        if (bit_cnt == rx_out_pkg::LANE_LAST)
        begin
            next_word    = next_shift;
            next_par_clk = 1'b1;
        end
        else if (bit_cnt == rx_out_pkg::PCLK_FALL)
        begin
            next_par_clk = 1'b0;
        end
    end

    // register the deserialiser state
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            shift   <= 4'h0;
            bit_cnt <= 2'h0;
            aux_cnt <= 4'h0;
            word    <= 4'h0;
            par_clk <= 1'b0;
        end
        else
        begin
            shift   <= next_shift;
            bit_cnt <= next_bit_cnt;
            aux_cnt <= next_aux_cnt;
            word    <= next_word;
            par_clk <= next_par_clk;
        end
    end

    // derived outputs to the control side
    assign lane.word    = word;
    assign lane.par_clk = par_clk;
    assign lane.aux_clk = aux_cnt[rx_out_pkg::AUX_CNT_W-1];

endmodule : rx_deser4

// ### rx_out_props.sv
module rx_out_props
(
    input  wire logic       clk_i,                   // clock
    input  wire logic       rst_i,                   // reset
    input  wire logic       optical_signal_detect_i, // detect pin
    input  wire logic       sd_polarity_i,           // polarity pin
    input  wire logic       mute_on_los_i,           // mute pin
    input  wire logic       host_mode_i,             // host pin
    input  wire logic       cdr_lock_i,              // lock pin
    input  wire logic       rx_data_disable_i,       // disable pin
    input  wire logic [3:0] rx_par_data_o,           // lanes
    input  wire logic       rx_par_clk_out_o,        // parallel clock
    input  wire logic       rx_aux_div16_clk_o,      // aux clock
    input  wire logic       recovery_lock_ind_o,     // lock out
    input  wire logic       los_flag_out_o,          // loss out
    input  wire logic       irq_o,                   // interrupt
    input  wire logic       wb_cyc_i,                // bus cycle
    input  wire logic       wb_stb_i,                // bus strobe
    input  wire logic       wb_ack_o                 // bus ack
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    // lane, clock, flag and bus acknowledge relations
    a_disable_zero: assert property (rx_data_disable_i |-> rx_par_data_o == 4'h0)
        else $error("lanes not zero while disabled");
    a_data_pclk: assert property (($changed(rx_par_data_o) && rx_par_data_o != 4'h0
        && !$past(rx_data_disable_i)) |-> $rose(rx_par_clk_out_o)) else $error("lanes moved off clock");
    a_pclk_shape: assert property ($rose(rx_par_clk_out_o) |-> rx_par_clk_out_o[*2]
        ##1 !rx_par_clk_out_o[*2] ##1 rx_par_clk_out_o) else $error("parallel clock shape");
    a_aux_shape: assert property ($rose(rx_aux_div16_clk_o) |-> rx_aux_div16_clk_o[*8]
        ##1 !rx_aux_div16_clk_o[*8] ##1 rx_aux_div16_clk_o) else $error("aux clock shape");
    a_lock_rise: assert property ($rose(cdr_lock_i) |-> ##[1:8] recovery_lock_ind_o)
        else $error("lock not shown");
    a_lock_fall: assert property ($fell(cdr_lock_i) |-> ##[1:8] !recovery_lock_ind_o)
        else $error("unlock not shown");
    a_los_set: assert property ((optical_signal_detect_i != sd_polarity_i)[*8] |-> los_flag_out_o)
        else $error("loss not flagged");
    a_los_clear: assert property ((optical_signal_detect_i == sd_polarity_i)[*8] |-> !los_flag_out_o)
        else $error("loss flag without loss");
    a_mute_pin: assert property ((los_flag_out_o && mute_on_los_i && !host_mode_i)[*8]
        |-> rx_par_data_o == 4'h0) else $error("lanes not muted");
    a_ack_once: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bad ack");

    // main scenarios reached
    c_irq: cover property (irq_o);
    c_loss: cover property ($rose(los_flag_out_o));
    c_both: cover property (rx_data_disable_i && los_flag_out_o && mute_on_los_i);
endmodule : rx_out_props

bind rx_par_out rx_out_props props_u (.clk_i, .rst_i, .optical_signal_detect_i, .sd_polarity_i,
    .mute_on_los_i, .host_mode_i, .cdr_lock_i, .rx_data_disable_i, .rx_par_data_o, .rx_par_clk_out_o,
    .rx_aux_div16_clk_o, .recovery_lock_ind_o, .los_flag_out_o, .irq_o, .wb_cyc_i, .wb_stb_i, .wb_ack_o);

// ### par_sink.sv
module par_sink
(
    input  wire logic       clk_i,     // bit clock
    input  wire logic       par_clk_i, // forwarded clock
    input  wire logic [3:0] data_i,    // lanes
    output logic      [3:0] word_o     // last word taken
);
    timeunit 1ns;
    timeprecision 100ps;
    logic prev;

    // take all four lanes at each parallel clock rise
    always @(posedge clk_i)
    begin
        prev <= par_clk_i;
        if (par_clk_i && !prev)
            word_o <= data_i;
    end
endmodule : par_sink

// ### tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk_i = 1'b0, rst_i = 1'b1, rx_serial_i = 1'b0;
    logic        optical_signal_detect_i = 1'b0, sd_polarity_i = 1'b0;
    logic        mute_on_los_i = 1'b0, host_mode_i = 1'b0, cdr_lock_i = 1'b0;
    logic        fec_rate_i = 1'b0, rx_data_disable_i = 1'b0;
    logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic        wb_ack_o, irq_o, los_flag_out_o, recovery_lock_ind_o;
    logic        rx_par_clk_out_o, rx_aux_div16_clk_o;
    logic [3:0]  rx_par_data_o, word, pat = 4'hF;
    logic [1:0]  cnt = 2'h0;
    int          error_cnt = 0, n_compared = 0, r = 0;

    rx_par_out dut_u (.clk_i, .rst_i, .rx_serial_i, .optical_signal_detect_i, .sd_polarity_i,
        .mute_on_los_i, .host_mode_i, .cdr_lock_i, .fec_rate_i, .rx_data_disable_i, .rx_par_data_o,
        .rx_par_clk_out_o, .rx_aux_div16_clk_o, .recovery_lock_ind_o, .los_flag_out_o, .irq_o,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
    par_sink sink_u (.clk_i, .par_clk_i(rx_par_clk_out_o), .data_i(rx_par_data_o), .word_o(word));

    // clock
    initial
        forever #20 clk_i = ~clk_i;

    // periodic serial stream, first bit of each 4-slot period is pat[3]
    always @(posedge clk_i)
    begin
        cnt <= cnt + 2'h1;
        rx_serial_i <= pat[~cnt];
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [3:0] rotl(input logic [3:0] v, input int n);
        logic [7:0] d;
        d = {v, v} << n;
        return d[7:4];
    endfunction : rotl

    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
    endtask : step

    // classic single cycle, held until ack is sampled; only the watchdog ends a hang
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_sel_i <= s;
        wb_dat_i <= d;
        @(posedge clk_i);
        while (wb_ack_o !== 1'b1)
            @(posedge clk_i);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
        chk(wb_ack_o, 0);
    endtask : wb

    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdchk

    task automatic t_regs;
        rdchk(rx_out_pkg::CTRL_ADDR, rx_out_pkg::CTRL_RESET);
        rdchk(rx_out_pkg::INT_STAT_ADDR, 32'h0);
        rdchk(rx_out_pkg::INT_MASK_ADDR, 32'h0);
        wb(1'b1, rx_out_pkg::INT_MASK_ADDR, 32'h3);
        rdchk(rx_out_pkg::INT_MASK_ADDR, 32'h3);
        wb(1'b1, rx_out_pkg::INT_MASK_ADDR, 32'h0, 4'h0);
        rdchk(rx_out_pkg::INT_MASK_ADDR, 32'h3);
        wb(1'b1, 4'h2, 32'hFF);
        rdchk(4'h2, 32'h0);
        $display("regs done");
    endtask : t_regs

    task automatic t_order;
        logic [15:0] tbl;
        tbl = 16'hCA1E;
        pat <= 4'h8;
        step(16);
        // groups count from reset release behind a four-cycle input latency
        r = 3;
        chk(word, rotl(4'h8, r));
        for (int i = 0; i < 4; i++)
        begin
            pat <= tbl[4*i +: 4];
            step(16);
            chk(word, rotl(tbl[4*i +: 4], r));
        end
        pat <= 4'hF;
        step(16);
        $display("order done");
    endtask : t_order

    task automatic t_los;
        for (int i = 0; i < 4; i++)
        begin
            sd_polarity_i <= i[1];
            optical_signal_detect_i <= i[0];
            step(12);
            chk(los_flag_out_o, i[1] ^ i[0]);
            rdchk(rx_out_pkg::STATUS_ADDR, i[1] ^ i[0]);
        end
        rdchk(rx_out_pkg::INT_STAT_ADDR, 32'h0);
        $display("loss done");
    endtask : t_los

    task automatic t_irq;
        host_mode_i <= 1'b1;
        step(8);
        for (int m = 1; m >= 0; m--)
        begin
            wb(1'b1, rx_out_pkg::INT_MASK_ADDR, 32'(m));
            optical_signal_detect_i <= 1'b0;
            step(12);
            rdchk(rx_out_pkg::INT_STAT_ADDR, 32'h1);
            chk(irq_o, m);
            optical_signal_detect_i <= 1'b1;
            step(12);
            wb(1'b1, rx_out_pkg::INT_STAT_ADDR, 32'h1);
            rdchk(rx_out_pkg::INT_STAT_ADDR, 32'h0);
            chk(irq_o, 0);
        end
        wb(1'b1, rx_out_pkg::INT_MASK_ADDR, 32'h3);
        host_mode_i <= 1'b0;
        step(8);
        $display("irq done");
    endtask : t_irq

    task automatic t_mute;
        mute_on_los_i <= 1'b1;
        optical_signal_detect_i <= 1'b0;
        step(12);
        chk(rx_par_data_o, 0);
        host_mode_i <= 1'b1;
        step(12);
        chk(rx_par_data_o, 4'hF);
        wb(1'b1, rx_out_pkg::CTRL_ADDR, 32'h1);
        step(8);
        chk(rx_par_data_o, 0);
        rdchk(rx_out_pkg::STATUS_ADDR, 32'h15);
        wb(1'b1, rx_out_pkg::CTRL_ADDR, 32'h0);
        host_mode_i <= 1'b0;
        mute_on_los_i <= 1'b0;
        step(12);
        chk(rx_par_data_o, 4'hF);
        $display("mute done");
    endtask : t_mute

    task automatic t_force;
        mute_on_los_i <= 1'b1;
        rx_data_disable_i <= 1'b1;
        @(negedge clk_i);
        chk(rx_par_data_o, 0);
        step(12);
        rx_data_disable_i <= 1'b0;
        step(4);
        chk(rx_par_data_o, 0);
        optical_signal_detect_i <= 1'b1;
        step(16);
        chk(rx_par_data_o, 4'hF);
        rx_data_disable_i <= 1'b1;
        @(negedge clk_i);
        chk(rx_par_data_o, 0);
        @(posedge clk_i);
        rx_data_disable_i <= 1'b0;
        @(negedge clk_i);
        chk(rx_par_data_o, 4'hF);
        @(posedge clk_i);
        $display("force done");
    endtask : t_force

    // count rising edges of both forwarded clocks over 64 cycles
    task automatic t_clks;
        logic [7:0] na;
        logic [7:0] np;
        logic       pa;
        logic       pp;
        na = 8'h00;
        np = 8'h00;
        @(negedge clk_i);
        pa = rx_aux_div16_clk_o;
        pp = rx_par_clk_out_o;
        repeat (64)
        begin
            @(negedge clk_i);
            na = na + 8'(rx_aux_div16_clk_o & ~pa);
            np = np + 8'(rx_par_clk_out_o & ~pp);
            pa = rx_aux_div16_clk_o;
            pp = rx_par_clk_out_o;
        end
        chk(na, 8'h04);
        chk(np, 8'h10);
        @(posedge clk_i);
        $display("clocks done");
    endtask : t_clks

    task automatic t_lock;
        fec_rate_i <= 1'b1;
        cdr_lock_i <= 1'b1;
        step(12);
        chk(recovery_lock_ind_o, 1);
        rdchk(rx_out_pkg::STATUS_ADDR, 32'hA);
        cdr_lock_i <= 1'b0;
        step(12);
        chk(recovery_lock_ind_o, 0);
        rdchk(rx_out_pkg::INT_STAT_ADDR, 32'h2);
        chk(irq_o, 1);
        wb(1'b1, rx_out_pkg::INT_STAT_ADDR, 32'h2);
        rdchk(rx_out_pkg::INT_STAT_ADDR, 32'h0);
        $display("lock done");
    endtask : t_lock

    task automatic tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish

    // main sequence
    initial
    begin
        step(12);
        rst_i <= 1'b0;
        t_regs;
        t_order;
        t_los;
        t_irq;
        t_mute;
        t_force;
        t_clks;
        t_lock;
        tally_and_finish;
    end

    // watchdog
    initial
    begin
        step(20000);
        error_cnt++;
        tally_and_finish;
    end
endmodule : tb_top
